// ==== rtl/egc_global_config_regs.sv ====
// Global EEE configuration registers behind an indirect byte window
`timescale 1ns/1ps
module egc_global_config_regs #(
    parameter int NPORTS = egc_pkg::EGC_NPORTS,
    parameter int UNIT_CYC = egc_pkg::EGC_UNIT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Byte register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Port status
    input wire logic eee_100_en,
    input wire logic [NPORTS-1:0] transmit_queue_empty,
    input wire logic [NPORTS-1:0] transmit_queue_push,
    input wire logic [NPORTS-1:0] low_power_idle_exit,
    input wire logic [NPORTS-1:0] phy_ready,
    // Controls and counters
    output logic [NPORTS-1:0] low_power_idle_req,
    output logic [NPORTS-1:0] next_page_en,
    output logic [15:0] wake_err_count
);
    import egc_pkg::*;

    localparam int UW = $clog2(UNIT_CYC);
    localparam int WW = $clog2(EGC_WAKE_CYC + 1);
    localparam logic [UW-1:0] UNIT_LAST = UW'(UNIT_CYC - 1);
    localparam logic [WW-1:0] WAKE_LAST = WW'(EGC_WAKE_CYC - 1);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] ofs_q, ofs_d;
    logic [15:0] wait_q, wait_d;
    logic [3:0] np_q, np_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic sel;
    logic [7:0] win_byte;

    // Window open only for EEE table and global group
    assign sel = ctrl_q[EGC_TSEL_HI:EGC_TSEL_LO] == EGC_TABLE_EEE
        && ctrl_q[EGC_GRP_HI:EGC_GRP_LO] == EGC_GROUP_GLOBAL;

    // Byte seen through the data window
    always_comb begin
        win_byte = 8'h00;
        if (sel) begin
            case (ofs_q)
                EGC_OFS_WAIT_HI: win_byte = wait_q[15:8];
                EGC_OFS_WAIT_LO: win_byte = wait_q[7:0];
                EGC_OFS_NP_HI: win_byte = EGC_NP_RSVD[11:4];
                EGC_OFS_NP_LO: win_byte = {EGC_NP_RSVD[3:0], np_q};
                EGC_OFS_MINIDLE_HI: win_byte = EGC_MINIDLE_VAL[15:8];
                EGC_OFS_MINIDLE_LO: win_byte = EGC_MINIDLE_VAL[7:0];
                EGC_OFS_WAKE_HI: win_byte = EGC_WAKE_LIMIT[15:8];
                EGC_OFS_WAKE_LO: win_byte = EGC_WAKE_LIMIT[7:0];
                EGC_OFS_PCS_HI: win_byte = EGC_PCS_VAL[15:8];
                EGC_OFS_PCS_LO: win_byte = EGC_PCS_VAL[7:0];
                default: win_byte = 8'h00;
            endcase
        end
    end

    // Writes and read answers; wake limit and reserved bytes ignore writes
    always_comb begin
        ctrl_d = ctrl_q;
        ofs_d = ofs_q;
        wait_d = wait_q;
        np_d = np_q;
        rdata_d = rdata_q;
        rvalid_d = reg_rd;
        if (reg_wr) begin
            case (reg_addr)
                EGC_ADDR_CTRL: ctrl_d = reg_wdata;
                EGC_ADDR_OFS: ofs_d = reg_wdata;
                EGC_ADDR_DATA: begin
                    if (sel) begin
                        case (ofs_q)
                            EGC_OFS_WAIT_HI: wait_d[15:8] = reg_wdata;
                            EGC_OFS_WAIT_LO: wait_d[7:0] = reg_wdata;
                            EGC_OFS_NP_LO: np_d = reg_wdata[3:0];
                            default: wait_d = wait_q;
                        endcase
                    end
                end
                default: ctrl_d = ctrl_q;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                EGC_ADDR_CTRL: rdata_d = ctrl_q;
                EGC_ADDR_OFS: rdata_d = ofs_q;
                EGC_ADDR_DATA: rdata_d = win_byte;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= 8'h00;
            ofs_q <= 8'h00;
            wait_q <= EGC_WAIT_RST;
            np_q <= EGC_NP_RST;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ofs_q <= ofs_d;
            wait_q <= wait_d;
            np_q <= np_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign next_page_en = np_q;

    // ----------------------------------------------------------------
    // Time-base dividers
    // ----------------------------------------------------------------
    logic [UW-1:0] ucnt_q, ucnt_d;
    logic [WW-1:0] wcnt_q, wcnt_d;
    logic utick_q, utick_d, wtick_q, wtick_d;

    // One pulse per idle unit and per wake unit
    always_comb begin
        utick_d = (ucnt_q == UNIT_LAST);
        ucnt_d = utick_d ? '0 : ucnt_q + UW'(1);
        wtick_d = (wcnt_q == WAKE_LAST);
        wcnt_d = wtick_d ? '0 : wcnt_q + WW'(1);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ucnt_q <= '0;
            wcnt_q <= '0;
            utick_q <= 1'b0;
            wtick_q <= 1'b0;
        end else begin
            ucnt_q <= ucnt_d;
            wcnt_q <= wcnt_d;
            utick_q <= utick_d;
            wtick_q <= wtick_d;
        end
    end

    // ----------------------------------------------------------------
    // Port timers
    // ----------------------------------------------------------------
    logic [NPORTS-1:0] req_w, err_w;

    // One timer per port, all sharing the single wait setting
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        egc_timer_if tif ();
        assign tif.unit_tick = utick_q;
        assign tif.wake_tick = wtick_q;
        assign tif.eee_en = eee_100_en;
        assign tif.wait_val = wait_q;
        assign tif.wake_limit = EGC_WAKE_LIMIT;
        assign tif.queue_empty = transmit_queue_empty[p];
        assign tif.queue_push = transmit_queue_push[p];
        assign tif.idle_exit = low_power_idle_exit[p];
        assign tif.phy_ready = phy_ready[p];
        assign req_w[p] = tif.idle_req;
        assign err_w[p] = tif.wake_err;
        egc_port_timer u_timer (
            .clk(clk),
            .sys_rst(sys_rst),
            .tif(tif.timer)
        );
    end

    // ----------------------------------------------------------------
    // Requests and wake-up error counter
    // ----------------------------------------------------------------
    logic [NPORTS-1:0] req_q;
    logic [15:0] errc_q, errc_d;

    // Saturating sum of wake errors from all ports
    always_comb begin
        errc_d = errc_q;
        for (int i = 0; i < NPORTS; i++) begin
            if (err_w[i] && errc_d != 16'hFFFF) begin
                errc_d = errc_d + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_q <= '0;
            errc_q <= 16'h0000;
        end else begin
            req_q <= req_w;
            errc_q <= errc_d;
        end
    end

    assign low_power_idle_req = req_q;
    assign wake_err_count = errc_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_reset_values: assert property (@(posedge clk) disable iff (1'b0) sys_rst |=>
        wait_q == EGC_WAIT_RST && np_q == EGC_NP_RST)
        else $error("bad reset values");

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_table_gate: assert property ((reg_wr && reg_addr == EGC_ADDR_DATA
        && ctrl_q[EGC_TSEL_HI:EGC_TSEL_LO] != EGC_TABLE_EEE)
        |=> $stable(wait_q) && $stable(np_q))
        else $error("write through closed table");
    chk_group_gate: assert property ((reg_wr && reg_addr == EGC_ADDR_DATA
        && ctrl_q[EGC_GRP_HI:EGC_GRP_LO] != EGC_GROUP_GLOBAL)
        |=> $stable(wait_q) && $stable(np_q))
        else $error("write to wrong group");
    chk_wait_hi_write: assert property ((reg_wr && reg_addr == EGC_ADDR_DATA && sel
        && ofs_q == EGC_OFS_WAIT_HI) |=> wait_q[15:8] == $past(reg_wdata))
        else $error("wait high byte not written");
    chk_wait_lo_read: assert property ((reg_rd && reg_addr == EGC_ADDR_DATA && sel
        && ofs_q == EGC_OFS_WAIT_LO) |=> reg_rvalid && reg_rdata == $past(wait_q[7:0]))
        else $error("wait low byte read wrong");
    chk_wake_limit_ro: assert property ((reg_rd && reg_addr == EGC_ADDR_DATA && sel
        && ofs_q == EGC_OFS_WAKE_HI) |=> reg_rdata == EGC_WAKE_LIMIT[15:8])
        else $error("wake limit byte wrong");
    chk_np_write: assert property ((reg_wr && reg_addr == EGC_ADDR_DATA && sel
        && ofs_q == EGC_OFS_NP_LO) |=> next_page_en == $past(reg_wdata[3:0]))
        else $error("next-page enables not written");
    chk_err_count_step: assert property ((|err_w && errc_q != 16'hFFFF)
        |=> wake_err_count > $past(wake_err_count))
        else $error("wake error not counted");
    cov_window_read: cover property (reg_rd && reg_addr == EGC_ADDR_DATA && sel);
    cov_np_clear: cover property (np_q != EGC_NP_RST);
    cov_err_count: cover property (wake_err_count != 16'h0000);
endmodule // egc_global_config_regs

// ==== rtl/egc_pkg.sv ====
// Constants and types for the global EEE configuration register bank
package egc_pkg;
    // ----------------------------------------------------------------
    // Directly addressed registers
    // ----------------------------------------------------------------
    localparam logic [7:0] EGC_ADDR_CTRL = 8'h6E;
    localparam logic [7:0] EGC_ADDR_OFS = 8'h6F;
    localparam logic [7:0] EGC_ADDR_DATA = 8'hA0;
    // Indirect control fields
    localparam int EGC_TSEL_HI = 7;
    localparam int EGC_TSEL_LO = 5;
    localparam int EGC_GRP_HI = 3;
    localparam int EGC_GRP_LO = 0;
    localparam logic [2:0] EGC_TABLE_EEE = 3'h1;
    localparam logic [3:0] EGC_GROUP_GLOBAL = 4'h0;
    // ----------------------------------------------------------------
    // Indirect byte offsets, even byte is the high half
    // ----------------------------------------------------------------
    localparam logic [7:0] EGC_OFS_WAIT_HI = 8'h32;
    localparam logic [7:0] EGC_OFS_WAIT_LO = 8'h33;
    localparam logic [7:0] EGC_OFS_NP_HI = 8'h34;
    localparam logic [7:0] EGC_OFS_NP_LO = 8'h35;
    localparam logic [7:0] EGC_OFS_MINIDLE_HI = 8'h36;
    localparam logic [7:0] EGC_OFS_MINIDLE_LO = 8'h37;
    localparam logic [7:0] EGC_OFS_WAKE_HI = 8'h38;
    localparam logic [7:0] EGC_OFS_WAKE_LO = 8'h39;
    localparam logic [7:0] EGC_OFS_PCS_HI = 8'h3A;
    localparam logic [7:0] EGC_OFS_PCS_LO = 8'h3B;
    // Reset and fixed values
    localparam logic [15:0] EGC_WAIT_RST = 16'h0010;
    localparam logic [3:0] EGC_NP_RST = 4'hF;
    localparam logic [11:0] EGC_NP_RSVD = 12'h680;
    localparam logic [15:0] EGC_MINIDLE_VAL = 16'h0000;
    localparam logic [15:0] EGC_WAKE_LIMIT = 16'h0201;
    localparam logic [15:0] EGC_PCS_VAL = 16'h0001;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int EGC_NPORTS = 4;
    localparam int EGC_CLK_MHZ = 100;
    localparam int EGC_UNIT_US = 1300;
    localparam int EGC_UNIT_CYC = EGC_UNIT_US * EGC_CLK_MHZ;
    localparam int EGC_WAKE_UNIT_NS = 10;
    localparam int EGC_WAKE_CYC = (EGC_WAKE_UNIT_NS * EGC_CLK_MHZ + 999) / 1000;
    // Wake-up meter states
    typedef enum logic [0:0] {EGC_WK_IDLE, EGC_WK_MEASURE} egc_wake_state_t;
endpackage

// ==== rtl/egc_port_timer.sv ====
// Per-port empty-queue idle timer and PHY wake-up meter
`timescale 1ns/1ps
module egc_port_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Link to the register bank
    egc_timer_if.timer tif
);
    import egc_pkg::*;

    // ----------------------------------------------------------------
    // Empty-queue idle timer
    // ----------------------------------------------------------------
    logic [15:0] idle_q, idle_d;
    logic req_q, req_d;

    // Count unit ticks while queue empty, request once past the wait
    always_comb begin
        idle_d = idle_q;
        req_d = req_q;
        if (!tif.eee_en || tif.queue_push || !tif.queue_empty) begin
            idle_d = '0;
            req_d = 1'b0;
        end else begin
            if (tif.unit_tick && idle_q != 16'hFFFF) begin
                idle_d = idle_q + 16'h0001;
            end
            if (idle_q > tif.wait_val) begin
                req_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idle_q <= '0;
            req_q <= 1'b0;
        end else begin
            idle_q <= idle_d;
            req_q <= req_d;
        end
    end

    assign tif.idle_req = req_q;

    // ----------------------------------------------------------------
    // Wake-up meter
    // ----------------------------------------------------------------
    egc_wake_state_t st_q, st_d;
    logic [15:0] wcnt_q, wcnt_d;
    logic err_q, err_d;

    // Time from idle exit to PHY ready, flag once past the limit
    always_comb begin
        st_d = st_q;
        wcnt_d = wcnt_q;
        err_d = 1'b0;
        case (st_q)
            EGC_WK_IDLE: begin
                if (tif.idle_exit) begin
                    st_d = EGC_WK_MEASURE;
                    wcnt_d = '0;
                end
            end
            EGC_WK_MEASURE: begin
                if (tif.phy_ready) begin
                    st_d = EGC_WK_IDLE;
                end else if (tif.wake_tick && wcnt_q != 16'hFFFF) begin
                    wcnt_d = wcnt_q + 16'h0001;
                    err_d = (wcnt_q == tif.wake_limit);
                end
            end
            default: st_d = EGC_WK_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= EGC_WK_IDLE;
            wcnt_q <= '0;
            err_q <= 1'b0;
        end else begin
            st_q <= st_d;
            wcnt_q <= wcnt_d;
            err_q <= err_d;
        end
    end

    assign tif.wake_err = err_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_req_needs_enable: assert property (!tif.eee_en |=> !req_q)
        else $error("idle request while EEE disabled");
    chk_push_restarts_timer: assert property (tif.queue_push |=>
        idle_q == 16'h0000 && !req_q)
        else $error("push did not restart idle timer");
    chk_req_after_wait: assert property ((tif.eee_en && tif.queue_empty
        && !tif.queue_push && idle_q > tif.wait_val) |=> req_q)
        else $error("idle request missing after wait");
    chk_wake_err_limit: assert property (err_q |->
        $past(wcnt_q) == $past(tif.wake_limit) && $past(st_q) == EGC_WK_MEASURE)
        else $error("wake error not at limit");
    cov_idle_req: cover property (!req_q ##1 req_q);
    cov_wake_err: cover property (err_q);
endmodule // egc_port_timer

// ==== rtl/egc_timer_if.sv ====
// Per-port link between the register bank and one port timer
`timescale 1ns/1ps
interface egc_timer_if;
    logic unit_tick;
    logic wake_tick;
    logic eee_en;
    logic [15:0] wait_val;
    logic [15:0] wake_limit;
    logic queue_empty;
    logic queue_push;
    logic idle_exit;
    logic phy_ready;
    logic idle_req;
    logic wake_err;
    // Register bank side
    modport ctrl (output unit_tick, wake_tick, eee_en, wait_val, wake_limit, queue_empty,
        queue_push, idle_exit, phy_ready, input idle_req, wake_err);
    // Port timer side
    modport timer (input unit_tick, wake_tick, eee_en, wait_val, wake_limit, queue_empty,
        queue_push, idle_exit, phy_ready, output idle_req, wake_err);
endinterface // egc_timer_if

// ==== testbench/tb.sv ====
// Self-checking bench for the global EEE configuration register bank
`timescale 1ns/1ps
module tb;
    import egc_pkg::*;

    // ----------------------------------------------------------------
    // Settings and signals
    // ----------------------------------------------------------------
    localparam int UC = 8;
    localparam int LIMIT = 20000;
    logic clk;
    logic sys_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic eee_100_en;
    logic [3:0] transmit_queue_empty;
    logic [3:0] transmit_queue_push;
    logic [3:0] low_power_idle_exit;
    logic [3:0] phy_ready;
    logic [3:0] low_power_idle_req;
    logic [3:0] next_page_en;
    logic [15:0] wake_err_count;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;

    // Short unit so the idle timer fires within a few dozen cycles
    egc_global_config_regs #(.NPORTS(4), .UNIT_CYC(UC)) dut (
        .clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .eee_100_en(eee_100_en), .transmit_queue_empty(transmit_queue_empty),
        .transmit_queue_push(transmit_queue_push), .low_power_idle_exit(low_power_idle_exit),
        .phy_ready(phy_ready), .low_power_idle_req(low_power_idle_req),
        .next_page_en(next_page_en), .wake_err_count(wake_err_count)
    );

    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            $display("BAD timeout expected done seen %0d cycles", cyc);
            fail_count++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    // One write strobe, then an idle cycle so strobes never abut
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask

    // Read strobe, bounded wait for the valid pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int k;
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        for (k = 0; k < 3 && reg_rvalid !== 1'b1; k++) tick();
        chk("read_valid", 16'h0001, {15'h0000, reg_rvalid});
        d = reg_rdata;
        tick();
    endtask

    task automatic iwr(input logic [7:0] ofs, input logic [7:0] d);
        wr(EGC_ADDR_OFS, ofs);
        wr(EGC_ADDR_DATA, d);
    endtask

    task automatic rchk(input string nm, input logic [7:0] ofs, input logic [7:0] e);
        logic [7:0] d;
        wr(EGC_ADDR_OFS, ofs);
        rd(EGC_ADDR_DATA, d);
        chk(nm, {8'h00, e}, {8'h00, d});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset values of next_page_en, wake_err_count and every global byte
    task automatic t_reset();
        logic [7:0] exp [10] = '{8'h00, 8'h10, 8'h68, 8'h0F, 8'h00, 8'h00, 8'h02, 8'h01,
            8'h00, 8'h01};
        chk("np_en_rst", 16'h000F, {12'h000, next_page_en});
        chk("err_rst", 16'h0000, wake_err_count);
        wr(EGC_ADDR_CTRL, 8'h20);
        for (int i = 0; i < 10; i++) begin
            rchk("reset_byte", 8'h32 + 8'(i), exp[i]);
        end
        $display("test reset done");
    endtask

    // Window closed unless table and group both match
    task automatic t_select();
        logic [7:0] d;
        wr(EGC_ADDR_CTRL, 8'h40);
        rchk("wrong_table", 8'h33, 8'h00);
        wr(EGC_ADDR_CTRL, 8'h23);
        rd(EGC_ADDR_CTRL, d);
        chk("ctrl_back", 16'h0023, {8'h00, d});
        rchk("port_group", 8'h33, 8'h00);
        rd(EGC_ADDR_OFS, d);
        chk("ofs_back", 16'h0033, {8'h00, d});
        iwr(8'h33, 8'h55);
        rd(8'h10, d);
        chk("unmapped", 16'h0000, {8'h00, d});
        wr(EGC_ADDR_CTRL, 8'h20);
        rchk("closed_write", 8'h33, 8'h10);
        $display("test select done");
    endtask

    // Byte halves, writable fields and read-only places
    task automatic t_rw();
        iwr(8'h32, 8'hA5);
        iwr(8'h33, 8'h3C);
        rchk("wait_hi", 8'h32, 8'hA5);
        rchk("wait_lo", 8'h33, 8'h3C);
        iwr(8'h32, 8'hFF);
        iwr(8'h33, 8'hFF);
        rchk("wait_max", 8'h33, 8'hFF);
        iwr(8'h35, 8'hF5);
        rchk("np_lo", 8'h35, 8'h05);
        chk("np_en", 16'h0005, {12'h000, next_page_en});
        iwr(8'h34, 8'hFF);
        rchk("np_hi_ro", 8'h34, 8'h68);
        iwr(8'h38, 8'hAA);
        iwr(8'h39, 8'hAA);
        rchk("wake_hi_ro", 8'h38, 8'h02);
        rchk("wake_lo_ro", 8'h39, 8'h01);
        iwr(8'h35, 8'h0F);
        iwr(8'h32, 8'h00);
        iwr(8'h33, 8'h02);
        $display("test rw done");
    endtask

    // Idle request timing, restart on push, gating by enable
    task automatic t_idle();
        int n = 0;
        transmit_queue_empty = 4'hF;
        repeat (5 * UC) tick();
        chk("req_disabled", 16'h0000, {12'h000, low_power_idle_req});
        eee_100_en = 1'b1;
        while (low_power_idle_req !== 4'hF && n < 6 * UC) begin
            tick();
            n++;
        end
        chk("req_all", 16'h000F, {12'h000, low_power_idle_req});
        chk("req_delay", 16'h0001, {15'h0000, n >= 2 * UC && n <= 4 * UC});
        transmit_queue_push = 4'h2;
        tick();
        transmit_queue_push = 4'h0;
        repeat (3) tick();
        chk("req_push", 16'h000D, {12'h000, low_power_idle_req});
        eee_100_en = 1'b0;
        repeat (4) tick();
        chk("req_off", 16'h0000, {12'h000, low_power_idle_req});
        transmit_queue_empty = 4'h0;
        $display("test idle done");
    endtask

    // Slow wake counts one error, prompt wake counts none
    task automatic t_wake();
        logic [15:0] c0;
        c0 = wake_err_count;
        phy_ready = 4'hE;
        low_power_idle_exit = 4'h1;
        tick();
        low_power_idle_exit = 4'h0;
        repeat (500) tick();
        chk("err_early", c0, wake_err_count);
        repeat (40) tick();
        chk("err_late", c0 + 16'h0001, wake_err_count);
        repeat (100) tick();
        chk("err_once", c0 + 16'h0001, wake_err_count);
        phy_ready = 4'hF;
        tick();
        phy_ready = 4'hB;
        low_power_idle_exit = 4'h4;
        tick();
        low_power_idle_exit = 4'h0;
        repeat (400) tick();
        phy_ready = 4'hF;
        repeat (300) tick();
        chk("err_prompt", c0 + 16'h0001, wake_err_count);
        $display("test wake done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        eee_100_en = 1'b0;
        transmit_queue_empty = 4'h0;
        transmit_queue_push = 4'h0;
        low_power_idle_exit = 4'h0;
        phy_ready = 4'hF;
        repeat (12) tick();
        sys_rst = 1'b0;
        tick();
        t_reset();
        t_select();
        t_rw();
        t_idle();
        t_wake();
        end_sim();
    end
endmodule // tb
